// ===== common/wdg_pkg.sv
// package for the watchdog block: register map, field layout, reset values, timing
// assumes a 32-bit apb slave, one aligned word per register
package wdg_pkg;
  // printed offsets are not all multiples of four: index here, byte address is index * 4
  localparam logic [7:0]  CTRL_IDX       = 8'h9F;
  localparam logic [7:0]  SYSTEM_CONFIG_REG_IDX      = 8'hBF;
  localparam logic [7:0]  IRQ_STAT_IDX   = 8'hC0;
  localparam logic [7:0]  IRQ_MASK_IDX   = 8'hC1;
  localparam logic [7:0]  COUNT_IDX      = 8'hC2;
  localparam logic [11:0] CTRL_ADDR      = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] SYSTEM_CONFIG_REG_ADDR     = {2'h0, SYSTEM_CONFIG_REG_IDX, 2'h0};
  localparam logic [11:0] IRQ_STAT_ADDR  = {2'h0, IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR  = {2'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [11:0] COUNT_ADDR     = {2'h0, COUNT_IDX, 2'h0};
  // control register fields
  localparam int          CTRL_EN_BIT    = 7;
  localparam int          CTRL_CLR_BIT   = 5;
  localparam int          CTRL_PS_LSB    = 0;
  localparam int          PS_W           = 3;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  // system configuration fields
  localparam int          SYSTEM_CONFIG_REG_WDR_BIT  = 7;
  localparam int          SYSTEM_CONFIG_REG_OME_BIT  = 1;
  localparam int          SYSTEM_CONFIG_REG_STROBE_INHIBIT_BIT_BIT = 0;
  localparam logic [7:0]  SYSTEM_CONFIG_REG_RST      = 8'h02;
  // interrupt status bits
  localparam int          IRQ_W          = 2;
  localparam int          IRQ_OVF_BIT    = 0;
  localparam int          IRQ_KICK_BIT   = 1;
  // counter and divider
  localparam int          CNT_W          = 16;
  localparam int          DIV_BASE_LOG2  = 3;
  localparam int          DIV_W          = 10;
  localparam int          STROBE_DIV     = 6;
  localparam int          RST_PULSE_CYC  = 4;
  localparam real         CLK_MHZ        = 40.0;

  typedef struct packed {
    logic          en;
    logic [PS_W-1:0] ps;
  } wdg_ctrl_t;
endpackage

// ===== test/tb.sv
// self-checking bench for the watchdog block: apb master, queued read checks, pin checks
// assumes wdg_top with CNT_W shortened to 8 so an overflow fits in a short run
`timescale 1ns/1ps
module tb;
  logic        i_clk, i_nrst, i_wdr_seen, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, o_prdata, seed;
  logic        o_pready, o_pslverr, o_dog_reset, o_strobe, o_irq;
  logic [32:0] me, mm;
  logic [32:0] q_e[$], q_m[$];
  int          n_mismatch, n_tests, k, t, hi;

  wdg_top #(.CNT_W(8), .DIV_W(wdg_pkg::DIV_W)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_wdr_seen(i_wdr_seen),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_dog_reset(o_dog_reset), .o_strobe(o_strobe), .o_irq(o_irq));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic results;
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // masked compare so unknown bits in checked positions never match
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s, input logic [32:0] m);
    n_tests++;
    if (((s ^ e) & m) !== 33'h0) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge i_clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    q_e.push_back(e);
    q_m.push_back(m);
    @(posedge i_clk);
    pen <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (t == 50) begin
      n_mismatch++;
      results();
    end
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  // every completed transfer takes the oldest note, read data and error flag together
  always @(posedge i_clk) begin
    if (psel === 1'b1 && pen === 1'b1 && o_pready === 1'b1 && q_e.size() > 0) begin
      me = q_e.pop_front();
      mm = q_m.pop_front();
      chk("apb", me, {o_pslverr, o_prdata}, mm);
    end
  end

  initial begin
    i_nrst = 1'b0; i_wdr_seen = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; seed = 32'hB8397E5F; n_mismatch = 0; n_tests = 0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(wdg_pkg::CTRL_ADDR, 32'h0, 32'hFFFFFFA7);
    rd(wdg_pkg::SYSTEM_CONFIG_REG_ADDR, 32'h2, 32'hFFFFFFFF);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hFFFFFFFF});
    for (k = 0; k < 8; k++) begin
      seed = xs(seed);
      wr(wdg_pkg::CTRL_ADDR, (seed & 32'hFFFFFF58) | k);
      rd(wdg_pkg::CTRL_ADDR, k, 32'hFFFFFFA7);
    end
    // divide by 8 then by 16 over the same window: count halves
    for (k = 0; k < 2; k++) begin
      wr(wdg_pkg::CTRL_ADDR, 32'h0);
      wr(wdg_pkg::CTRL_ADDR, 32'h80 | k);
      repeat (64) @(posedge i_clk);
      rd(wdg_pkg::COUNT_ADDR, 32'h8 >> k, 32'hFFFFFFFC);
    end
    wr(wdg_pkg::IRQ_MASK_ADDR, 32'h0);
    wr(wdg_pkg::CTRL_ADDR, 32'hA0);
    rd(wdg_pkg::CTRL_ADDR, 32'h80, 32'hFFFFFFA7);
    rd(wdg_pkg::COUNT_ADDR, 32'h0, 32'hFFFFFFFC);
    @(posedge i_clk);
    chk_pin("irq masked", 1'b0, o_irq);
    rd(wdg_pkg::IRQ_STAT_ADDR, 32'h2, 32'h2);
    wr(wdg_pkg::IRQ_MASK_ADDR, 32'h2);
    @(posedge i_clk);
    chk_pin("irq", 1'b1, o_irq);
    wr(wdg_pkg::IRQ_STAT_ADDR, 32'h2);
    @(posedge i_clk);
    chk_pin("irq cleared", 1'b0, o_irq);
    wr(wdg_pkg::SYSTEM_CONFIG_REG_ADDR, 32'h3);
    repeat (2) @(posedge i_clk);
    repeat (12) begin
      @(posedge i_clk);
      chk_pin("strobe", 1'b0, o_strobe);
    end
    wr(wdg_pkg::SYSTEM_CONFIG_REG_ADDR, 32'h2);
    repeat (2) @(posedge i_clk);
    hi = 0;
    repeat (12) begin
      @(posedge i_clk);
      hi += (o_strobe === 1'b1);
    end
    chk_pin("strobe duty", 1'b1, hi == 6);
    // periodic kicks well inside the 2048-cycle timeout keep the reset away
    repeat (3) begin
      repeat (1500) @(posedge i_clk);
      wr(wdg_pkg::CTRL_ADDR, 32'hA0);
      chk_pin("no reset", 1'b0, o_dog_reset);
    end
    // restart from zero, then let it run out: 256 ticks of 8 clocks
    wr(wdg_pkg::CTRL_ADDR, 32'hA0);
    for (k = 0; k < 4000 && o_dog_reset !== 1'b1; k++) @(posedge i_clk);
    if (k == 4000) begin
      n_mismatch++;
      results();
    end
    chk_pin("timeout", 1'b1, k > 2030 && k < 2070);
    for (t = 0; t < 10 && o_dog_reset === 1'b1; t++) @(posedge i_clk);
    chk_pin("reset pulse", 1'b1, t == wdg_pkg::RST_PULSE_CYC);
    // the pulse is fed back as the device reset, as the system would
    i_nrst <= 1'b0;
    i_wdr_seen <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_wdr_seen <= 1'b0;
    rd(wdg_pkg::SYSTEM_CONFIG_REG_ADDR, 32'h82, 32'hFFFFFFFF);
    rd(wdg_pkg::CTRL_ADDR, 32'h0, 32'hFFFFFFA7);
    rd(wdg_pkg::COUNT_ADDR, 32'h0, 32'hFFFFFFFF);
    chk_pin("dog reset idle", 1'b0, o_dog_reset);
    results();
  end
endmodule // tb

// ===== verilog/wdg_prescale.sv
// prescaler: divider counting only while i_run, giving a one-cycle tick every 2^(ps+3) clocks
// assumes a single clock; i_sync_clr restarts the division phase
`timescale 1ns/1ps
module wdg_prescale #(
  parameter int DIV_W = wdg_pkg::DIV_W
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // control
  input  wire logic       i_run,
  input  wire logic       i_sync_clr,
  input  wire logic [2:0] i_ps,
  // tick out
  output logic            o_tick
);
  initial begin
    if (DIV_W < wdg_pkg::DIV_BASE_LOG2 + 7) $error("prescaler too narrow");
  end

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] mask;

  // divide by 2^(ps+3): tick when the low ps+3 bits are all ones
  always_comb begin
    mask = DIV_W'((1 << (int'(i_ps) + wdg_pkg::DIV_BASE_LOG2)) - 1);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= '0;
    end else if (!i_run || i_sync_clr) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  assign o_tick = i_run && !i_sync_clr && ((div_r & mask) == mask);
endmodule // wdg_prescale

// ===== verilog/wdg_top.sv
// watchdog timer with address-strobe inhibit, apb register slave
// assumes i_nrst is the device reset (pin or watchdog); o_dog_reset is fed back into it
// Behaviour
// - 16-bit counter overflows into device reset
// - control bit 7 one enables watchdog
// - counter advances on prescaled tick when enabled
// - enable clears on every device reset
// - control bit 5 one zeroes counter
// - prescale divides by two to field plus three
// - control layout en7 clr5 ps2..0, resets zero
// - timeout is 65536 divided-clock periods
// - config bit 0 stops divide-by-six strobe
// - watchdog overflow sets config bit 7
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module wdg_top #(
  parameter int CNT_W = wdg_pkg::CNT_W,
  parameter int DIV_W = wdg_pkg::DIV_W
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // flag that the last reset came from the watchdog (held outside the reset domain)
  input  wire logic        i_wdr_seen,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // device reset request
  output logic             o_dog_reset,
  // address-latch strobe pin
  output logic             o_strobe,
  // interrupt
  output logic             o_irq
);
  initial begin
    // shorter counters are allowed so a bench can reach overflow quickly
    if (CNT_W < 2 || CNT_W > 32) $error("counter width out of range");
  end

  localparam logic [2:0] STROBE_LAST = 3'(wdg_pkg::STROBE_DIV - 1);
  localparam logic [2:0] PULSE_LAST  = 3'(wdg_pkg::RST_PULSE_CYC - 1);

  typedef enum logic [1:0] {WDG_IDLE, WDG_RUN, WDG_FIRE} wdg_state_t;

  wdg_state_t            state_r;
  wdg_pkg::wdg_ctrl_t    ctrl_r;
  logic                  clr_req_r;
  logic [CNT_W-1:0]      cnt_r;
  logic [2:0]            pulse_r;
  logic                  wdr_r;
  logic                  ome_r;
  logic                  strobe_inhibit_bit_r;
  logic [2:0]            strobe_cnt_r;
  logic                  strobe_r;
  logic [wdg_pkg::IRQ_W-1:0] stat_r;
  logic [wdg_pkg::IRQ_W-1:0] mask_r;
  logic [31:0]           rdata_r;
  logic                  tick;
  logic                  wr_en;
  logic                  rd_en;
  logic                  hit;
  logic                  overflow;
  logic [7:0]            wbyte;

  // apb: zero wait states, unmapped address answers pslverr
  assign wr_en     = i_psel && i_penable && i_pwrite;
  assign rd_en     = i_psel && i_penable && !i_pwrite;
  assign wbyte     = i_pstrb[0] ? i_pwdata[7:0] : 8'h00;
  assign hit       = (i_paddr == wdg_pkg::CTRL_ADDR) || (i_paddr == wdg_pkg::SYSTEM_CONFIG_REG_ADDR) ||
                     (i_paddr == wdg_pkg::IRQ_STAT_ADDR) || (i_paddr == wdg_pkg::IRQ_MASK_ADDR) ||
                     (i_paddr == wdg_pkg::COUNT_ADDR);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata  = rdata_r;

  // control register: writes take effect with strobe on lane 0 only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= '0;
    end else if (wr_en && i_pstrb[0] && i_paddr == wdg_pkg::CTRL_ADDR) begin
      ctrl_r.en <= wbyte[wdg_pkg::CTRL_EN_BIT];
      ctrl_r.ps <= wbyte[wdg_pkg::CTRL_PS_LSB +: wdg_pkg::PS_W];
    end
  end

  // clear request is consumed in the next cycle, so it never reads back as one
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_req_r <= 1'b0;
    end else begin
      clr_req_r <= wr_en && i_pstrb[0] && i_paddr == wdg_pkg::CTRL_ADDR &&
                   wbyte[wdg_pkg::CTRL_CLR_BIT];
    end
  end

  wdg_prescale #(
    .DIV_W (DIV_W)
  ) u_prescale (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_run      (state_r == WDG_RUN),
    .i_sync_clr (clr_req_r),
    .i_ps       (ctrl_r.ps),
    .o_tick     (tick)
  );

  assign overflow = tick && (cnt_r == {CNT_W{1'b1}});

  // state: counting starts after enable, fire holds a short reset pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= WDG_IDLE;
    end else begin
      unique case (state_r)
        WDG_IDLE: begin
          if (ctrl_r.en) begin
            state_r <= WDG_RUN;
          end
        end
        WDG_RUN: begin
          if (!ctrl_r.en) begin
            state_r <= WDG_IDLE;
          end else if (overflow) begin
            state_r <= WDG_FIRE;
          end
        end
        WDG_FIRE: begin
          if (pulse_r == PULSE_LAST) begin
            state_r <= WDG_IDLE;
          end
        end
      endcase
    end
  end

  // counter: zeroed on reset, clear request or disable; wraps at overflow
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= '0;
    end else if (clr_req_r || state_r != WDG_RUN) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_r <= '0;
    end else if (state_r == WDG_FIRE) begin
      pulse_r <= pulse_r + 3'h1;
    end else begin
      pulse_r <= '0;
    end
  end

  // reset pulse stretched so the device reset logic catches it
  assign o_dog_reset = (state_r == WDG_FIRE);

  // system configuration: reset source flag is caught after release, not under reset
  logic wdr_load_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdr_load_r <= 1'b1;
    end else begin
      wdr_load_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdr_r  <= 1'b0;
      ome_r  <= wdg_pkg::SYSTEM_CONFIG_REG_RST[wdg_pkg::SYSTEM_CONFIG_REG_OME_BIT];
      strobe_inhibit_bit_r <= 1'b0;
    end else if (wdr_load_r && i_wdr_seen) begin
      wdr_r <= 1'b1;
    end else if (overflow) begin
      wdr_r <= 1'b1;
    end else if (wr_en && i_pstrb[0] && i_paddr == wdg_pkg::SYSTEM_CONFIG_REG_ADDR) begin
      wdr_r  <= wbyte[wdg_pkg::SYSTEM_CONFIG_REG_WDR_BIT];
      ome_r  <= wbyte[wdg_pkg::SYSTEM_CONFIG_REG_OME_BIT];
      strobe_inhibit_bit_r <= wbyte[wdg_pkg::SYSTEM_CONFIG_REG_STROBE_INHIBIT_BIT_BIT];
    end
  end

  // address strobe: clock divided by six, suppressed while inhibit is set
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strobe_cnt_r <= '0;
      strobe_r     <= 1'b0;
    end else begin
      strobe_cnt_r <= (strobe_cnt_r == STROBE_LAST) ? 3'h0 : strobe_cnt_r + 3'h1;
      strobe_r     <= !strobe_inhibit_bit_r && (strobe_cnt_r < 3'(wdg_pkg::STROBE_DIV / 2));
    end
  end
  assign o_strobe = strobe_r;

  // interrupt status: sticky, write one to clear, a new event wins over the clear
  logic [wdg_pkg::IRQ_W-1:0] ev;
  assign ev[wdg_pkg::IRQ_OVF_BIT]  = overflow;
  assign ev[wdg_pkg::IRQ_KICK_BIT] = clr_req_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_r <= '0;
    end else if (wr_en && i_pstrb[0] && i_paddr == wdg_pkg::IRQ_STAT_ADDR) begin
      stat_r <= (stat_r & ~wbyte[wdg_pkg::IRQ_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_r <= '0;
    end else if (wr_en && i_pstrb[0] && i_paddr == wdg_pkg::IRQ_MASK_ADDR) begin
      mask_r <= wbyte[wdg_pkg::IRQ_W-1:0];
    end
  end

  assign o_irq = |(stat_r & mask_r);

  // read data registered on the edge that ends the setup cycle; pready is immediate, so read
  // data is taken combinationally from the setup-cycle registered copy
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        wdg_pkg::CTRL_ADDR:     rdata_r <= {24'h0, ctrl_r.en, 2'b00, 2'b00, ctrl_r.ps};
        wdg_pkg::SYSTEM_CONFIG_REG_ADDR:    rdata_r <= {24'h0, wdr_r, 5'h00, ome_r, strobe_inhibit_bit_r};
        wdg_pkg::IRQ_STAT_ADDR: rdata_r <= {30'h0, stat_r};
        wdg_pkg::IRQ_MASK_ADDR: rdata_r <= {30'h0, mask_r};
        wdg_pkg::COUNT_ADDR:    rdata_r <= 32'(cnt_r);
        default:                rdata_r <= 32'h0;
      endcase
    end
  end

  // a clear restarts the divider phase, so the tick spacing check skips the next window
  logic [2:0] clr_age_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_age_r <= 3'h0;
    end else if (clr_req_r) begin
      clr_age_r <= 3'h7;
    end else if (clr_age_r != 3'h0) begin
      clr_age_r <= clr_age_r - 3'h1;
    end
  end

  // checks
  wdg_en_reset_a: assert property (@(posedge i_clk) $rose(i_nrst) |-> !ctrl_r.en)
    else $error("enable not cleared by reset");
  dog_overflow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == WDG_RUN && ctrl_r.en && overflow) |=> o_dog_reset[*4] ##1 !o_dog_reset)
    else $error("overflow did not give reset pulse");
  cnt_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    clr_req_r |=> cnt_r == '0)
    else $error("clear did not zero counter");
  clr_oneshot_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    clr_req_r |=> !clr_req_r || $past(wr_en))
    else $error("clear request stuck");
  cnt_advance_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == WDG_RUN && ctrl_r.en && tick && !clr_req_r && !overflow) |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("counter missed a tick");
  idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == WDG_IDLE) |=> cnt_r == '0)
    else $error("counter moved while disabled");
  wdr_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    overflow |=> wdr_r)
    else $error("reset flag not set");
  strobe_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    strobe_inhibit_bit_r |=> !o_strobe)
    else $error("strobe not inhibited");
  tick_rate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (tick && ctrl_r.ps == 3'h0 && state_r == WDG_RUN && ctrl_r.en && !clr_req_r) |=>
      !tick[*7] ##1 (tick || state_r != WDG_RUN || ctrl_r.ps != 3'h0 || clr_req_r || clr_age_r != 3'h0))
    else $error("divide by eight broken");
endmodule // wdg_top
